//--- core/tccc_defines.svh
`ifndef TCCC_DEFINES_SVH
`define TCCC_DEFINES_SVH

// register indices; the byte address is four times the index
`define TCCC_CH1_HI_IDX   14'h0034
`define TCCC_CH1_LO_IDX   14'h0035
`define TCCC_CH2_HI_IDX   14'h0457
`define TCCC_CH2_LO_IDX   14'h0458
`define TCCC_CH3_HI_IDX   14'h045A
`define TCCC_CH3_LO_IDX   14'h045B
`define TCCC_CH4_HI_IDX   14'h045D
`define TCCC_CH4_LO_IDX   14'h045E
`define TCCC_CH1_CTL_IDX  14'h0460
`define TCCC_CH2_CTL_IDX  14'h0461
`define TCCC_CH3_CTL_IDX  14'h0462
`define TCCC_CH4_CTL_IDX  14'h0463

// channel control register fields
`define TCCC_CTL_FLAG     7
`define TCCC_CTL_MSB      5
`define TCCC_CTL_MSA      4
`define TCCC_CTL_ELSH     3
`define TCCC_CTL_ELSL     2
`define TCCC_CTL_TOV      1
`define TCCC_CTL_MAX      0
`define TCCC_CTL_RESET    8'h00

`endif

//--- core/tccc_pkg.sv
`default_nettype none
package tccc_pkg;
   typedef enum logic [1:0] {
      TCCC_ELS_PORT,
      TCCC_ELS_RISE_TOGGLE,
      TCCC_ELS_FALL_CLEAR,
      TCCC_ELS_BOTH_SET
   } tccc_els_t;

   typedef enum logic [1:0] {
      TCCC_ACC_NONE,
      TCCC_ACC_HI,
      TCCC_ACC_LO,
      TCCC_ACC_CTL
   } tccc_acc_t;
endpackage
`default_nettype wire

//--- core/tccc_channels.sv
`default_nettype none
`include "tccc_defines.svh"

module tccc_channels
   import tccc_pkg::*;
#(
   parameter int NCH = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [15:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic [31:0]      prdata,
   output var  logic             pready,
   output var  logic             pslverr,
   input  wire logic [15:0]      counter_value,
   input  wire logic             counter_wrap,
   input  wire logic [NCH-1:0]   channel_pin_in,
   output var  logic [NCH-1:0]   channel_pin_out,
   output var  logic [NCH-1:0]   channel_pin_oe,
   output var  logic [NCH-1:0]   channel_event_flag
);

   if (NCH < 1 || NCH > 4) begin : g_bad_nch
      $error("tccc_channels: NCH must be 1 to 4");
   end

   localparam logic [13:0] HI_IDX [4]  = '{`TCCC_CH1_HI_IDX, `TCCC_CH2_HI_IDX,
                                           `TCCC_CH3_HI_IDX, `TCCC_CH4_HI_IDX};
   localparam logic [13:0] LO_IDX [4]  = '{`TCCC_CH1_LO_IDX, `TCCC_CH2_LO_IDX,
                                           `TCCC_CH3_LO_IDX, `TCCC_CH4_LO_IDX};
   localparam logic [13:0] CTL_IDX [4] = '{`TCCC_CH1_CTL_IDX, `TCCC_CH2_CTL_IDX,
                                           `TCCC_CH3_CTL_IDX, `TCCC_CH4_CTL_IDX};

   // bus slave state
   logic [31:0]    prdata_q, prdata_d;
   logic           pready_q, pready_d;
   logic           pslverr_q, pslverr_d;

   // channel control state
   logic [NCH-1:0] flag_q, flag_d;
   logic [NCH-1:0] msb_q, msb_d;
   logic [NCH-1:0] msa_q, msa_d;
   logic [NCH-1:0] elsh_q, elsh_d;
   logic [NCH-1:0] elsl_q, elsl_d;
   logic [NCH-1:0] tov_q, tov_d;
   logic [NCH-1:0] max_q, max_d;
   logic [NCH-1:0] maxeff_q, maxeff_d;
   logic [NCH-1:0] capblk_q, capblk_d;
   logic [NCH-1:0] cmpblk_q, cmpblk_d;
   logic [NCH-1:0] out_q, out_d;
   logic [NCH-1:0] oe_q, oe_d;
   logic [NCH-1:0] pin_prev_q, pin_prev_d;
   logic [15:0]    value_q [NCH];
   logic [15:0]    value_d [NCH];

   // decode and per-channel combinational terms
   tccc_acc_t      acc_kind [NCH];
   tccc_els_t      els [NCH];
   logic [NCH-1:0] capture;
   logic [NCH-1:0] compare;
   logic [NCH-1:0] cap_ev;
   logic [NCH-1:0] match;
   logic           setup;
   logic           access;
   logic           hit;

   assign setup  = psel & ~penable;
   assign access = psel & penable & pready_q;

   always_comb begin
      hit = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         if (paddr == {HI_IDX[c], 2'b00}) begin
            acc_kind[c] = TCCC_ACC_HI;
         end else if (paddr == {LO_IDX[c], 2'b00}) begin
            acc_kind[c] = TCCC_ACC_LO;
         end else if (paddr == {CTL_IDX[c], 2'b00}) begin
            acc_kind[c] = TCCC_ACC_CTL;
         end else begin
            acc_kind[c] = TCCC_ACC_NONE;
         end
         if (acc_kind[c] != TCCC_ACC_NONE) begin
            hit = 1'b1;
         end
      end
   end

   // bus slave: one wait-free access phase, read data fixed at setup
   // unmapped addresses answer with an error and read as zero
   always_comb begin
      pready_d  = setup;
      pslverr_d = setup & ~hit;
      prdata_d  = prdata_q;
      if (setup && !pwrite) begin
         prdata_d = 32'h0000_0000;
         for (int c = 0; c < NCH; c++) begin
            case (acc_kind[c])
               TCCC_ACC_HI:  prdata_d[7:0] = value_q[c][15:8];
               TCCC_ACC_LO:  prdata_d[7:0] = value_q[c][7:0];
               TCCC_ACC_CTL: prdata_d[7:0] = {flag_q[c], 1'b0, msb_q[c], msa_q[c],
                                              elsh_q[c], elsl_q[c], tov_q[c], max_q[c]};
               default:      ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic rise;
         logic fall;
         logic active;
         logic wr_hi;
         logic wr_lo;
         logic wr_ctl;
         logic rd_hi;
         logic rd_lo;
         active = 1'b0;
         rise   = channel_pin_in[c] & ~pin_prev_q[c];
         fall   = ~channel_pin_in[c] & pin_prev_q[c];
         wr_hi  = access & pwrite & (acc_kind[c] == TCCC_ACC_HI);
         wr_lo  = access & pwrite & (acc_kind[c] == TCCC_ACC_LO);
         wr_ctl = access & pwrite & (acc_kind[c] == TCCC_ACC_CTL);
         rd_hi  = access & ~pwrite & (acc_kind[c] == TCCC_ACC_HI);
         rd_lo  = access & ~pwrite & (acc_kind[c] == TCCC_ACC_LO);
         els[c]     = tccc_els_t'({elsh_q[c], elsl_q[c]});
         capture[c] = ~msb_q[c] & ~msa_q[c] & (els[c] != TCCC_ELS_PORT);
         compare[c] = msb_q[c] | msa_q[c];

         case (els[c])
            TCCC_ELS_RISE_TOGGLE: active = rise;
            TCCC_ELS_FALL_CLEAR:  active = fall;
            TCCC_ELS_BOTH_SET:    active = rise | fall;
            default:              active = 1'b0;
         endcase
         cap_ev[c] = capture[c] & active & ~capblk_q[c];
         match[c]  = compare[c] & (counter_value == value_q[c]) & ~cmpblk_q[c];

         pin_prev_d[c] = channel_pin_in[c];
         flag_d[c]     = flag_q[c];
         msb_d[c]      = msb_q[c];
         msa_d[c]      = msa_q[c];
         elsh_d[c]     = elsh_q[c];
         elsl_d[c]     = elsl_q[c];
         tov_d[c]      = tov_q[c];
         max_d[c]      = max_q[c];
         if (wr_ctl) begin
            msb_d[c]  = pwdata[`TCCC_CTL_MSB];
            msa_d[c]  = pwdata[`TCCC_CTL_MSA];
            elsh_d[c] = pwdata[`TCCC_CTL_ELSH];
            elsl_d[c] = pwdata[`TCCC_CTL_ELSL];
            tov_d[c]  = pwdata[`TCCC_CTL_TOV];
            max_d[c]  = pwdata[`TCCC_CTL_MAX];
            if (!pwdata[`TCCC_CTL_FLAG]) begin
               flag_d[c] = 1'b0;
            end
         end
         // a new event in the clearing cycle survives the clear
         if (cap_ev[c] || match[c]) begin
            flag_d[c] = 1'b1;
         end

         capblk_d[c] = capblk_q[c];
         if (rd_lo) begin
            capblk_d[c] = 1'b0;
         end else if (rd_hi && capture[c]) begin
            capblk_d[c] = 1'b1;
         end
         cmpblk_d[c] = cmpblk_q[c];
         if (wr_lo) begin
            cmpblk_d[c] = 1'b0;
         end else if (wr_hi && compare[c]) begin
            cmpblk_d[c] = 1'b1;
         end

         // force level only moves at a PWM cycle boundary
         maxeff_d[c] = counter_wrap ? max_q[c] : maxeff_q[c];

         value_d[c] = value_q[c];
         if (cap_ev[c]) begin
            value_d[c] = counter_value;
         end
         if (wr_hi) begin
            value_d[c][15:8] = pwdata[7:0];
         end
         if (wr_lo) begin
            value_d[c][7:0] = pwdata[7:0];
         end

         oe_d[c]  = compare[c] & (els[c] != TCCC_ELS_PORT);
         out_d[c] = out_q[c];
         if (els[c] == TCCC_ELS_PORT) begin
            out_d[c] = ~msa_q[c];
         end else if (compare[c]) begin
            if (tov_q[c] && els[c] == TCCC_ELS_FALL_CLEAR && maxeff_d[c]) begin
               out_d[c] = 1'b1;
            end else if (counter_wrap && tov_q[c]) begin
               out_d[c] = ~out_q[c];
            end else if (match[c]) begin
               case (els[c])
                  TCCC_ELS_RISE_TOGGLE: out_d[c] = ~out_q[c];
                  TCCC_ELS_FALL_CLEAR:  out_d[c] = 1'b0;
                  TCCC_ELS_BOTH_SET:    out_d[c] = 1'b1;
                  default:              out_d[c] = out_q[c];
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q     <= '0;
         msb_q      <= '0;
         msa_q      <= '0;
         elsh_q     <= '0;
         elsl_q     <= '0;
         tov_q      <= '0;
         max_q      <= '0;
         maxeff_q   <= '0;
         capblk_q   <= '0;
         cmpblk_q   <= '0;
         out_q      <= '0;
         oe_q       <= '0;
         pin_prev_q <= '0;
      end else begin
         flag_q     <= flag_d;
         msb_q      <= msb_d;
         msa_q      <= msa_d;
         elsh_q     <= elsh_d;
         elsl_q     <= elsl_d;
         tov_q      <= tov_d;
         max_q      <= max_d;
         maxeff_q   <= maxeff_d;
         capblk_q   <= capblk_d;
         cmpblk_q   <= cmpblk_d;
         out_q      <= out_d;
         oe_q       <= oe_d;
         pin_prev_q <= pin_prev_d;
      end
   end

   // value registers carry no reset: contents are undefined until written
   always_ff @(posedge pclk) begin
      for (int c = 0; c < NCH; c++) begin
         value_q[c] <= value_d[c];
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign channel_pin_out    = out_q;
   assign channel_pin_oe     = oe_q;
   assign channel_event_flag = flag_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_ready_a: assert property (setup |=> pready_q ##1 !pready_q)
      else $error("ready not one cycle after setup");

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      port_release_a: assert property (els[g] == TCCC_ELS_PORT |=> !oe_q[g])
         else $error("pin driven with select code 00");
      init_level_a: assert property (els[g] == TCCC_ELS_PORT |=> out_q[g] == !$past(msa_q[g]))
         else $error("wrong initial level");
      rise_cap_a: assert property (capture[g] && els[g] == TCCC_ELS_RISE_TOGGLE && !capblk_q[g]
                                   && channel_pin_in[g] && !pin_prev_q[g] && !access
                                   |=> value_q[g] == $past(counter_value) && flag_q[g])
         else $error("rising edge not captured");
      cap_block_a: assert property (capblk_q[g] && !access |=> value_q[g] == $past(value_q[g]))
         else $error("capture while blocked");
      cmp_block_a: assert property (compare[g] && cmpblk_q[g] && !flag_q[g] && !access
                                    |=> !flag_q[g])
         else $error("compare flag while blocked");
      wrap_toggle_a: assert property (compare[g] && els[g] != TCCC_ELS_PORT && tov_q[g] && counter_wrap
                                      && !(els[g] == TCCC_ELS_FALL_CLEAR && max_q[g])
                                      |=> out_q[g] == !$past(out_q[g]))
         else $error("wrap toggle missed or overridden");
      full_duty_a: assert property (compare[g] && tov_q[g] && els[g] == TCCC_ELS_FALL_CLEAR
                                    && maxeff_q[g] && !counter_wrap |=> out_q[g] [*1])
         else $error("full duty level not held high");
      max_latency_a: assert property (!counter_wrap |=> $stable(maxeff_q[g]))
         else $error("force changed inside PWM cycle");
      set_compare_a: assert property (match[g] && els[g] == TCCC_ELS_BOTH_SET
                                      && !(counter_wrap && tov_q[g]) |=> out_q[g])
         else $error("set on compare failed");
      match_flag_a: assert property (match[g] |=> flag_q[g])
         else $error("match did not set flag");
      // wrap and full duty are kept out, both outrank the compare action
      toggle_compare_a: assert property (match[g] && els[g] == TCCC_ELS_RISE_TOGGLE && !tov_q[g]
                                         |=> out_q[g] == !$past(out_q[g]))
         else $error("toggle on compare failed");
      clear_compare_a: assert property (match[g] && els[g] == TCCC_ELS_FALL_CLEAR && !tov_q[g]
                                        |=> !out_q[g])
         else $error("clear on compare failed");
      capture_release_a: assert property (capture[g] |=> !oe_q[g])
         else $error("pin driven in capture mode");
      capture_level_a: assert property (capture[g] |=> $stable(out_q[g]))
         else $error("output moved on a capture channel");

      capture_c: cover property (cap_ev[g] ##1 flag_q[g]);
      force_c: cover property (counter_wrap && max_q[g] && tov_q[g] ##1 maxeff_q[g]);
      block_c: cover property (capblk_q[g] ##[1:20] !capblk_q[g]);
      wrap_beats_c: cover property (match[g] && counter_wrap && tov_q[g] ##1 flag_q[g]);
   end

endmodule
`default_nettype wire

//--- test/tccc_pin_model.sv
`default_nettype none
module tccc_pin_model (
   input  wire logic [3:0] ext_level,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   output var  logic [3:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // a released pin follows the outside driver, a driven one echoes the block
   always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
`include "tccc_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [13:0] ctl_i = `TCCC_CH1_CTL_IDX;
   localparam logic [13:0] hi_i  = `TCCC_CH1_HI_IDX;
   localparam logic [13:0] lo_i  = `TCCC_CH1_LO_IDX;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, counter_wrap;
   logic [15:0] paddr, counter_value, cmp;
   logic [31:0] pwdata, prdata;
   logic [3:0]  ext_level, pin_in, pin_out, pin_oe, flag;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int          n_fail, checked;

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   tccc_channels #(.NCH(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_value(counter_value), .counter_wrap(counter_wrap), .channel_pin_in(pin_in),
      .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .channel_event_flag(flag));

   tccc_pin_model far (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   task automatic final_report();
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic fail(input string m);
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic chk(input logic g, input logic x, input string m);
      checked++;
      if (g !== x) fail(m);
   endtask

   task automatic note(input string m);
      $display("test %s done", m);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // the expected read is queued at setup and judged by the monitor
   task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d, input logic [32:0] x);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      penable <= 1'b0;
      if (!w) exp_q.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         fail("no pready");
         final_report();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask

   task automatic rd(input logic [13:0] idx, input logic [7:0] x);
      apb(1'b0, idx, 8'h00, {25'h0, x});
   endtask

   // counter parks on ~cmp, which never matches the compare value
   task automatic hit(input logic [15:0] v, input logic w);
      @(posedge pclk);
      counter_value <= v;
      counter_wrap <= w;
      @(posedge pclk);
      counter_value <= ~cmp;
      counter_wrap <= 1'b0;
      cyc(2);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            fail("unexpected read");
         end else begin
            e = exp_q.pop_front();
            checked++;
            if ({pslverr, prdata} !== e) fail("read data");
         end
      end
   end

   initial begin
      logic [15:0] ra, rb;
      logic        pre;
      int          c;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      counter_value = 16'h0;
      counter_wrap = 1'b0;
      ext_level = 4'h0;
      cmp = 16'hFFFF;
      n_fail = 0;
      checked = 0;
      void'($urandom(32'h88820785));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      chk(pin_oe[0], 1'b0, "oe after reset");
      chk(pin_out[0], 1'b1, "initial level");
      chk(pin_out[3], 1'b1, "initial level ch4");
      for (c = 0; c < 4; c++) rd(14'(ctl_i + c), 8'h00);
      apb(1'b0, 14'h0100, 8'h00, {1'b1, 32'h0});
      note("reset");
      for (c = 1; c < 4; c++) begin
         wr(ctl_i, 8'(c << 2));
         ra = 16'($urandom);
         rb = 16'($urandom);
         counter_value <= ra;
         ext_level <= 4'h1;
         cyc(3);
         chk(flag[0], c != 2, "rising edge");
         wr(ctl_i, 8'(c << 2));
         counter_value <= rb;
         ext_level <= 4'h0;
         cyc(3);
         chk(flag[0], c != 1, "falling edge");
         rd(hi_i, c == 1 ? ra[15:8] : rb[15:8]);
         rd(lo_i, c == 1 ? ra[7:0] : rb[7:0]);
      end
      ra = 16'($urandom);
      rb = ~ra;
      counter_value <= ra;
      ext_level <= 4'h1;
      cyc(3);
      rd(hi_i, ra[15:8]);
      counter_value <= rb;
      ext_level <= 4'h0;
      cyc(3);
      rd(lo_i, ra[7:0]);
      ext_level <= 4'h1;
      cyc(3);
      rd(hi_i, rb[15:8]);
      rd(lo_i, rb[7:0]);
      note("capture");
      cmp = 16'($urandom);
      counter_value <= ~cmp;
      wr(ctl_i, 8'h10);
      cyc(2);
      chk(pin_oe[0], 1'b0, "soft compare oe");
      chk(pin_out[0], 1'b0, "preset level");
      wr(hi_i, cmp[15:8]);
      wr(lo_i, cmp[7:0]);
      for (c = 3; c > 0; c--) begin
         wr(ctl_i, 8'(8'h10 | (c << 2)));
         pre = pin_out[0];
         hit(cmp, 1'b0);
         chk(pin_oe[0], 1'b1, "compare oe");
         chk(pin_out[0], c == 1 ? ~pre : c == 3, "compare action");
         chk(flag[0], 1'b1, "match flag");
      end
      wr(ctl_i, 8'h18);
      hit(cmp ^ 16'h0100, 1'b0);
      chk(flag[0], 1'b0, "partial match");
      wr(hi_i, ~cmp[15:8]);
      hit(cmp, 1'b0);
      hit({~cmp[15:8], cmp[7:0]}, 1'b0);
      chk(flag[0], 1'b0, "compare blocked");
      wr(lo_i, cmp[7:0]);
      cmp = {~cmp[15:8], cmp[7:0]};
      hit(cmp, 1'b0);
      chk(flag[0], 1'b1, "compare resumed");
      note("compare");
      wr(ctl_i, 8'h1A);
      pre = pin_out[0];
      hit(~cmp, 1'b1);
      chk(pin_out[0], ~pre, "wrap toggle");
      pre = pin_out[0];
      // pick the action that would keep the level, so only the toggle moves it
      wr(ctl_i, pre ? 8'h1E : 8'h1A);
      hit(cmp, 1'b1);
      chk(pin_out[0], ~pre, "wrap beats compare");
      note("wrap");
      wr(ctl_i, 8'h1B);
      hit(cmp, 1'b0);
      chk(pin_out[0], 1'b0, "force not yet");
      hit(~cmp, 1'b1);
      chk(pin_out[0], 1'b1, "forced high");
      hit(cmp, 1'b0);
      chk(pin_out[0], 1'b1, "force holds");
      wr(ctl_i, 8'h1A);
      hit(cmp, 1'b0);
      chk(pin_out[0], 1'b1, "force until wrap");
      hit(~cmp, 1'b1);
      chk(pin_out[0], 1'b0, "force released");
      note("full duty");
      wr(`TCCC_CH4_HI_IDX, cmp[15:8]);
      wr(`TCCC_CH4_LO_IDX, cmp[7:0]);
      wr(`TCCC_CH4_CTL_IDX, 8'h18);
      hit(cmp, 1'b0);
      chk(pin_oe[3], 1'b1, "ch4 oe");
      chk(pin_out[3], 1'b0, "ch4 clear");
      rd(`TCCC_CH4_CTL_IDX, 8'h98);
      note("channel 4");
      final_report();
   end
endmodule
`default_nettype wire
